// >>> brdc_map.svh
// Purpose: offsets, field positions, reset values and timing counts of the regulator control
// Assumes: 100 MHz system clock
// Notes: byte offsets on a 32-bit Avalon-MM slave
`ifndef BRDC_MAP_SVH
`define BRDC_MAP_SVH

`define BRDC_OFS_SET0 4'h0
`define BRDC_OFS_SET1 4'h4
`define BRDC_OFS_CTRL 4'h8
`define BRDC_OFS_STAT 4'hc

// setting register fields
`define BRDC_SET_EN_BIT 7
`define BRDC_SET_PWM_BIT 6
`define BRDC_SET_CODE_MSB 5

// control register fields
`define BRDC_CTRL_DIS_BIT 7
`define BRDC_CTRL_SLEW_MSB 6
`define BRDC_CTRL_SLEW_LSB 4

// reset values, sw enable bit kept apart
`define BRDC_SET0_RESET 7'h2d
`define BRDC_SET1_RESET 7'h7c
`define BRDC_CTRL_RESET 8'h00

`define BRDC_CLK_MHZ 100
`define BRDC_CL_COUNT 16
`define BRDC_RETRY_MS 1700
`define BRDC_SLEW_REF_MV 10
`define BRDC_SLEW_RATE0_MV_US 64
`define BRDC_SS_STEP_NS 1000

`endif

// >>> brdc_pkg.sv
// Purpose: types shared by the regulator control
// Assumes: nothing
// Notes: states are one-hot
package brdc_pkg;
	typedef enum logic [3:0]
	{
		BRDC_OFF = 4'b0001,
		BRDC_SOFT = 4'b0010,
		BRDC_RUN = 4'b0100,
		BRDC_FAULT = 4'b1000
	} brdc_state_t;
endpackage

// >>> brdc_core.sv
// Purpose: digital control core of a programmable step-down regulator
// Assumes: pin inputs asynchronous; sw_cycle_in is a square wave at the switching rate
// Notes: reference is carried in microvolts toward the modulator
// Function
// - enable pin low keeps everything but the discharge load and force_pwm_out off and refuses bus reads and writes
// - default build keeps register contents while enable pin is low
// - build option resets registers to defaults while enable pin is low
// - power-on reset loads all registers with defaults, both setting registers included
// - discharge load on when discharge bit set and enable pin or sw enable low
// - output on only with enable pin high and selected sw enable high
// - enabling output starts soft-start ramping reference up from zero
// - synchronous rectification held off until soft-start completes
// - 16 consecutive current-limit cycles: shut down, tri-state, retry after 1700 ms
// - reset value of both sw enable bits is a build parameter
// - build option forces the internal select low, always set 0
// - mode bit high forces PWM; low allows automatic light-load mode
// - select pin low uses set 0, high uses set 1, target follows
// - target equals offset plus voltage code times step
// - offset and step are build parameters covering all supported variants
// - 3-bit slew code halves upward rate from 64 mV/us to 0.5
// - effective slew scales with actual step over 10 mV
// - on falling target stop switching until output reaches new setpoint; a fall during soft-start only clamps the reference, switching goes on
// - input low lockout keeps regulator off while enable pin high
// - power ok low when off or in soft-start, high during transitions
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`include "brdc_map.svh"

module brdc_core #(
	parameter bit RESET_ON_DISABLE = 1'b0,
	parameter bit SELECT_TIED_LOW = 1'b0,
	parameter logic [1:0] SW_EN_RESET = 2'b11,
	parameter int unsigned OFFSET_UV = 600000,
	parameter int unsigned STEP_UV = 10000,
	parameter int unsigned RETRY_CYCLES = `BRDC_RETRY_MS * `BRDC_CLK_MHZ * 1000
)(
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	input wire logic hw_enable_pin_in,
	input wire logic voltage_set_select_pin_in,
	input wire logic input_low_lockout_in,
	input wire logic current_limit_in,
	input wire logic sw_cycle_in,
	input wire logic vout_at_target_in,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic output_on_out,
	output logic sync_rect_on_out,
	output logic force_pwm_out,
	output logic switch_node_hiz_out,
	output logic switching_stop_out,
	output logic discharge_on_out,
	output logic power_ok_flag_out,
	output logic [20:0] ref_uv_out
);
	import brdc_pkg::*;

	localparam int unsigned SS_CYCLES = (`BRDC_SS_STEP_NS * `BRDC_CLK_MHZ + 999) / 1000;

	// refuse builds that overflow the reference word or have no retry wait
	if (STEP_UV == 0 || OFFSET_UV + 63 * STEP_UV >= 2 ** 21 || RETRY_CYCLES < 1)
	begin
		$error("brdc_core: unsupported offset, step or retry count");
	end

	function automatic logic [31:0] slew_cycles(input logic [2:0] code);
		logic [31:0] num;
		num = (32'(`BRDC_SLEW_REF_MV * `BRDC_CLK_MHZ) << code) + 32'(`BRDC_SLEW_RATE0_MV_US - 1);
		return num / 32'(`BRDC_SLEW_RATE0_MV_US);
	endfunction

	// bit 0 enable, 1 select, 2 lockout, 3 current limit, 4 cycle, 5 at target
	logic [5:0] sync1;
	logic [5:0] sync2;
	logic cycle_d;
	logic [6:0] set0;
	logic [6:0] set1;
	logic [1:0] sw_en;
	logic [7:0] ctrl;
	brdc_state_t state;
	logic [20:0] ref_uv;
	logic [31:0] cnt;
	logic [4:0] cl_cnt;
	logic falling;

	logic [6:0] next_set0;
	logic [6:0] next_set1;
	logic [1:0] next_sw_en;
	logic [7:0] next_ctrl;
	brdc_state_t next_state;
	logic [20:0] next_ref_uv;
	logic [31:0] next_cnt;
	logic [4:0] next_cl_cnt;
	logic next_falling;
	logic [31:0] next_rdata;
	logic next_wait;

	logic en;
	logic sel;
	logic [6:0] active;
	logic sw_sel;
	logic want_on;
	logic [20:0] target_uv;
	logic cl_trip;
	logic bus_req;
	logic bus_go;

	always_comb
	begin
		en = sync2[0];
		sel = SELECT_TIED_LOW ? 1'b0 : sync2[1];
		active = sel ? set1 : set0;
		sw_sel = sel ? sw_en[1] : sw_en[0];
		want_on = en && sw_sel && !sync2[2];
		target_uv = 21'(OFFSET_UV + 32'(active[`BRDC_SET_CODE_MSB:0]) * STEP_UV);
		bus_req = avs_read || avs_write;
		bus_go = bus_req && !avs_waitrequest;
	end

	always_comb
	begin
		next_cl_cnt = cl_cnt;
		cl_trip = 1'b0;
		if (sync2[4] && !cycle_d)
		begin
			if (!sync2[3])
				next_cl_cnt = 5'h00;
			else if (cl_cnt == 5'(`BRDC_CL_COUNT - 1))
			begin
				next_cl_cnt = 5'h00;
				cl_trip = 1'b1;
			end
			else
				next_cl_cnt = cl_cnt + 5'h01;
		end
		if (state != BRDC_SOFT && state != BRDC_RUN)
			next_cl_cnt = 5'h00;
	end

	always_comb
	begin
		next_state = state;
		next_ref_uv = ref_uv;
		next_cnt = cnt;
		next_falling = falling;
		unique case (state)
			BRDC_OFF:
			begin
				next_ref_uv = 21'h000000;
				next_falling = 1'b0;
				next_cnt = 32'h00000000;
				if (want_on)
					next_state = BRDC_SOFT;
			end
			BRDC_SOFT:
			begin
				next_cnt = cnt + 32'h00000001;
				if (!want_on)
					next_state = BRDC_OFF;
				else if (cl_trip)
				begin
					next_state = BRDC_FAULT;
					next_cnt = 32'h00000000;
				end
				else if (ref_uv >= target_uv)
				begin
					next_ref_uv = target_uv;
					next_state = BRDC_RUN;
					next_cnt = 32'h00000000;
				end
				else if (cnt + 32'h00000001 >= SS_CYCLES)
				begin
					next_cnt = 32'h00000000;
					next_ref_uv = (ref_uv + 21'(STEP_UV) > target_uv) ? target_uv
						: ref_uv + 21'(STEP_UV);
				end
			end
			BRDC_RUN:
			begin
				next_cnt = cnt + 32'h00000001;
				if (!want_on)
					next_state = BRDC_OFF;
				else if (cl_trip)
				begin
					next_state = BRDC_FAULT;
					next_cnt = 32'h00000000;
				end
				else if (target_uv < ref_uv)
				begin
					next_ref_uv = target_uv;
					next_falling = 1'b1;
					next_cnt = 32'h00000000;
				end
				else if (target_uv > ref_uv)
				begin
					next_falling = 1'b0;
					// one step per interval scales with step
					if (cnt + 32'h00000001 >= slew_cycles(ctrl[`BRDC_CTRL_SLEW_MSB:`BRDC_CTRL_SLEW_LSB]))
					begin
						next_cnt = 32'h00000000;
						next_ref_uv = (ref_uv + 21'(STEP_UV) > target_uv) ? target_uv
							: ref_uv + 21'(STEP_UV);
					end
				end
				else
				begin
					next_cnt = 32'h00000000;
					if (falling && sync2[5])
						next_falling = 1'b0;
				end
			end
			BRDC_FAULT:
			begin
				next_ref_uv = 21'h000000;
				next_falling = 1'b0;
				next_cnt = cnt + 32'h00000001;
				if (!want_on || cnt + 32'h00000001 >= RETRY_CYCLES)
					next_state = BRDC_OFF;
			end
		endcase
	end

	always_comb
	begin
		next_set0 = set0;
		next_set1 = set1;
		next_sw_en = sw_en;
		next_ctrl = ctrl;
		next_rdata = avs_readdata;
		next_wait = !(avs_waitrequest && bus_req);
		// one wait state per access
		if (avs_waitrequest && avs_read)
		begin
			next_rdata = 32'h00000000;
			if (en)
			begin
				unique case (avs_address)
					`BRDC_OFS_SET0: next_rdata = {24'h000000, sw_en[0], set0};
					`BRDC_OFS_SET1: next_rdata = {24'h000000, sw_en[1], set1};
					`BRDC_OFS_CTRL: next_rdata = {24'h000000, ctrl};
					`BRDC_OFS_STAT: next_rdata = {4'h0, state, falling, 2'h0, ref_uv};
					default: next_rdata = 32'h00000000;
				endcase
			end
		end
		if (bus_go && avs_write && en)
		begin
			if (avs_address == `BRDC_OFS_SET0)
			begin
				next_set0 = avs_writedata[6:0];
				next_sw_en[0] = avs_writedata[`BRDC_SET_EN_BIT];
			end
			if (avs_address == `BRDC_OFS_SET1)
			begin
				next_set1 = avs_writedata[6:0];
				next_sw_en[1] = avs_writedata[`BRDC_SET_EN_BIT];
			end
			if (avs_address == `BRDC_OFS_CTRL)
				next_ctrl = avs_writedata[7:0] & 8'hf0;
		end
		if (RESET_ON_DISABLE && !en)
		begin
			next_set0 = `BRDC_SET0_RESET;
			next_set1 = `BRDC_SET1_RESET;
			next_sw_en = SW_EN_RESET;
			next_ctrl = `BRDC_CTRL_RESET;
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			sync1 <= 6'h00;
			sync2 <= 6'h00;
			cycle_d <= 1'b0;
			set0 <= `BRDC_SET0_RESET;
			set1 <= `BRDC_SET1_RESET;
			sw_en <= SW_EN_RESET;
			ctrl <= `BRDC_CTRL_RESET;
			state <= BRDC_OFF;
			ref_uv <= 21'h000000;
			cnt <= 32'h00000000;
			cl_cnt <= 5'h00;
			falling <= 1'b0;
			avs_readdata <= 32'h00000000;
			avs_waitrequest <= 1'b1;
			output_on_out <= 1'b0;
			sync_rect_on_out <= 1'b0;
			force_pwm_out <= 1'b0;
			switch_node_hiz_out <= 1'b1;
			switching_stop_out <= 1'b0;
			discharge_on_out <= 1'b0;
			power_ok_flag_out <= 1'b0;
			ref_uv_out <= 21'h000000;
		end
		else if (clk_en_in)
		begin
			sync1 <= {vout_at_target_in, sw_cycle_in, current_limit_in, input_low_lockout_in,
				voltage_set_select_pin_in, hw_enable_pin_in};
			sync2 <= sync1;
			cycle_d <= sync2[4];
			set0 <= next_set0;
			set1 <= next_set1;
			sw_en <= next_sw_en;
			ctrl <= next_ctrl;
			state <= next_state;
			ref_uv <= next_ref_uv;
			cnt <= next_cnt;
			cl_cnt <= next_cl_cnt;
			falling <= next_falling;
			avs_readdata <= next_rdata;
			avs_waitrequest <= next_wait;
			output_on_out <= next_state == BRDC_SOFT || next_state == BRDC_RUN;
			sync_rect_on_out <= next_state == BRDC_RUN;
			force_pwm_out <= active[`BRDC_SET_PWM_BIT];
			switch_node_hiz_out <= next_state == BRDC_OFF || next_state == BRDC_FAULT;
			switching_stop_out <= next_falling;
			discharge_on_out <= ctrl[`BRDC_CTRL_DIS_BIT] && (!en || !sw_sel);
			power_ok_flag_out <= next_state == BRDC_RUN;
			ref_uv_out <= next_ref_uv;
		end
	end

	on_needs_en_a:
		assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
			output_on_out |-> $past(en) && $past(sw_sel))
		else $error("output on without enables");
	off_when_disabled_a:
		assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
			clk_en_in && !en |=> !output_on_out && !sync_rect_on_out)
		else $error("output active while enable pin low");
	read_zero_disabled_a:
		assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
			clk_en_in && avs_waitrequest && avs_read && !en |=> avs_readdata == 32'h00000000)
		else $error("register read while disabled");
	rect_after_soft_a:
		assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
			state == BRDC_SOFT |-> !sync_rect_on_out)
		else $error("rectifier on in soft-start");
	soft_from_zero_a:
		assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
			clk_en_in && state == BRDC_OFF && want_on |=> ref_uv == 21'h000000 && state == BRDC_SOFT)
		else $error("soft-start not from zero");
	fault_hiz_a:
		assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
			state == BRDC_FAULT |-> switch_node_hiz_out && !output_on_out)
		else $error("fault without tri-state");
	discharge_rule_a:
		assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
			clk_en_in && ctrl[`BRDC_CTRL_DIS_BIT] && !en |=> discharge_on_out)
		else $error("discharge not applied");
	pwm_follow_a:
		assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
			clk_en_in |=> force_pwm_out == $past(active[`BRDC_SET_PWM_BIT]))
		else $error("forced pwm not following mode bit");
	good_regulating_a:
		assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
			power_ok_flag_out |-> state == BRDC_RUN)
		else $error("power ok outside regulation");
	ref_one_step_a:
		assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
			state == BRDC_RUN && $past(state) == BRDC_RUN && ref_uv > $past(ref_uv)
			|-> ref_uv - $past(ref_uv) <= 21'(STEP_UV))
		else $error("upward slew jumped more than one step");
	lockout_off_a:
		assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
			clk_en_in && sync2[2] |=> !output_on_out)
		else $error("running under lockout");

	soft_start_c: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		state == BRDC_SOFT ##1 state == BRDC_RUN);
	fall_c: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		$rose(falling));
	fault_c: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		state == BRDC_FAULT ##1 state == BRDC_OFF);
endmodule

// >>> brdc_stage_model.sv
// Purpose: behavioural power stage and output comparator
// Assumes: 100 MHz clock, switching period of 8 clocks
// Notes: overload_in makes every switching cycle end in limit
`timescale 1ns/1ps
module brdc_stage_model #(
	parameter int FALL_CYC = 50
)(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic overload_in,
	input wire logic stop_in,
	output logic sw_cycle_out,
	output logic limit_out,
	output logic at_target_out
);
	logic [2:0] div;
	int fall;
	assign sw_cycle_out = div[2];
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			div <= 3'h0;
			fall <= 0;
			limit_out <= 1'b0;
			at_target_out <= 1'b0;
		end
		else
		begin
			div <= div + 3'h1;
			fall <= stop_in ? fall + 1 : 0;
			at_target_out <= stop_in && fall >= FALL_CYC;
			limit_out <= overload_in;
		end
	end
endmodule

// >>> test_buck_regulator_digital_control.sv
// Purpose: self-checking bench of the regulator control core
// Assumes: retry wait shortened to 200 cycles
// Notes: reads are scored by a watcher against queued notes
`timescale 1ns/1ps
module test_buck_regulator_digital_control;
	logic sys_clk_in, reset_n_in, hw_enable_pin_in, voltage_set_select_pin_in;
	logic input_low_lockout_in, current_limit_in, sw_cycle_in, vout_at_target_in;
	logic avs_read, avs_write, avs_waitrequest, output_on_out, sync_rect_on_out;
	logic force_pwm_out, switch_node_hiz_out, switching_stop_out, discharge_on_out;
	logic power_ok_flag_out, overload, pok, clk_en;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, r;
	logic [20:0] ref_uv_out;
	logic [7:0] exp_q[$];
	int errors, checks_done, cyc, n, i, seed;

	initial
	begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end

	brdc_core #(.RETRY_CYCLES(200)) DUT (.sys_clk_in, .reset_n_in, .clk_en_in(clk_en),
		.hw_enable_pin_in, .voltage_set_select_pin_in, .input_low_lockout_in,
		.current_limit_in, .sw_cycle_in, .vout_at_target_in, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .output_on_out,
		.sync_rect_on_out, .force_pwm_out, .switch_node_hiz_out, .switching_stop_out,
		.discharge_on_out, .power_ok_flag_out, .ref_uv_out);

	brdc_stage_model PS (.clk_in(sys_clk_in), .reset_n_in, .overload_in(overload),
		.stop_in(switching_stop_out), .sw_cycle_out(sw_cycle_in),
		.limit_out(current_limit_in), .at_target_out(vout_at_target_in));

	task check(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want)
		begin
			errors++;
			$display("[ERR] %0t got %h want %h", $time, seen, want);
		end
	endtask

	task wrap_up;
		if (errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// for a read, d is the expected byte
	task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= wr;
		avs_read <= !wr;
		if (!wr)
			exp_q.push_back(d);
		do
			@(posedge sys_clk_in);
		while (avs_waitrequest);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk_in);
	endtask

	task hold(input int k);
		repeat (k) @(posedge sys_clk_in);
	endtask

	function logic pick(input int sel);
		case (sel)
			0: return output_on_out;
			1: return power_ok_flag_out;
			2: return switching_stop_out;
			3: return switch_node_hiz_out;
			default: return ref_uv_out == 21'd1200000;
		endcase
	endfunction

	// bounded wait, cycle count left in n
	task await(input int sel, input logic lvl, input int lim);
		n = 0;
		while (pick(sel) !== lvl && n < lim)
		begin
			@(posedge sys_clk_in);
			pok &= power_ok_flag_out;
			n++;
		end
	endtask

	always @(posedge sys_clk_in)
	begin
		cyc++;
		if (avs_read && !avs_waitrequest)
			check(avs_readdata[7:0], exp_q.size() ? exp_q.pop_front() : 8'hxx);
		if (cyc > 40000)
		begin
			errors++;
			wrap_up;
		end
	end

	initial
	begin
		seed = 11;
		{reset_n_in, hw_enable_pin_in, voltage_set_select_pin_in} = 3'b000;
		{input_low_lockout_in, overload, avs_read, avs_write, pok} = 5'h0;
		clk_en = 1'b1;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		hold(2);
		reset_n_in <= 1'b1;
		bus(0, 4'h0, 8'h00);
		bus(1, 4'h0, 8'h81);
		hw_enable_pin_in <= 1'b1;
		hold(3);
		bus(0, 4'h0, 8'had);
		bus(0, 4'h4, 8'hfc);
		bus(0, 4'h8, 8'h00);
		bus(0, 4'h2, 8'h00);
		for (i = 0; i < 4; i++)
		begin
			r = $random(seed);
			bus(1, 4'h4, {2'b11, r[5:0]});
			bus(0, 4'h4, {2'b11, r[5:0]});
		end
		bus(1, 4'h4, 8'hfc);
		// select held low after power-on
		await(0, 1'b1, 20);
		check(output_on_out, 1);
		hold(300);
		check({sync_rect_on_out, power_ok_flag_out}, 0);
		check(ref_uv_out < 21'd1050000 && ref_uv_out != 0, 1);
		await(1, 1'b1, 12000);
		check(ref_uv_out, 21'd1050000);
		check({sync_rect_on_out, force_pwm_out}, 2'b10);
		// status low byte is the reference, 0x100590 uV
		bus(0, 4'hc, 8'h90);
		// frozen clock enable: the new target must not move the reference
		voltage_set_select_pin_in <= 1'b1;
		clk_en <= 1'b0;
		hold(30);
		check(ref_uv_out, 21'd1050000);
		clk_en <= 1'b1;
		pok = 1'b1;
		await(4, 1'b1, 1000);
		// 15 steps of 16 cycles at slew code 0
		check(n > 236 && n < 252 && pok, 1);
		check(force_pwm_out, 1);
		bus(1, 4'h8, 8'h10);
		voltage_set_select_pin_in <= 1'b0;
		await(2, 1'b1, 10);
		check(switching_stop_out, 1);
		await(2, 1'b0, 100);
		check(n > 45 && n < 62 && ref_uv_out == 21'd1050000, 1);
		voltage_set_select_pin_in <= 1'b1;
		await(4, 1'b1, 1000);
		// 15 steps of 32 cycles at slew code 1
		check(n > 476 && n < 492, 1);
		bus(1, 4'h8, 8'h80);
		bus(1, 4'h4, 8'h7c);
		hold(8);
		check({output_on_out, discharge_on_out}, 2'b01);
		bus(1, 4'h4, 8'hfc);
		hold(8);
		check({output_on_out, discharge_on_out}, 2'b10);
		input_low_lockout_in <= 1'b1;
		hold(8);
		check(output_on_out, 0);
		input_low_lockout_in <= 1'b0;
		hold(10);
		check(output_on_out, 1);
		overload <= 1'b1;
		await(3, 1'b1, 200);
		// 16 limited cycles, 15 periods of 8 clocks apart, plus 5 to 12 of sync, phase and sampling
		check(n > 124 && n < 133 && !output_on_out, 1);
		overload <= 1'b0;
		hold(150);
		check({output_on_out, switch_node_hiz_out}, 2'b01);
		await(0, 1'b1, 100);
		check(n > 48 && n < 54, 1);
		hw_enable_pin_in <= 1'b0;
		hold(8);
		check({output_on_out, discharge_on_out, power_ok_flag_out}, 3'b010);
		bus(0, 4'h8, 8'h00);
		hold(2);
		wrap_up;
	end
endmodule
